//--- gffm_pkg.sv
// Constants shared by the gyro fault-flag monitor files
package gffm_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NVM_CHECK_US = 50;
  localparam int unsigned NVM_CHECK_CYC = (NVM_CHECK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned RAM_CHECK_US = 1;
  localparam int unsigned RAM_CHECK_CYC = (RAM_CHECK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned DECAY_MS = 50;
  localparam int unsigned DECAY_CYC = (DECAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned PERSIST_CYC = 16;
  localparam int unsigned ADDR_W = 9;
  localparam logic [ADDR_W-1:0] ADDR_QUAD = 9'h008;
  localparam logic [ADDR_W-1:0] ADDR_FHI = 9'h00A;
  localparam logic [ADDR_W-1:0] ADDR_FLO = 9'h00B;
  // High fault byte bit positions
  localparam int unsigned HI_GROSS = 3;
  localparam int unsigned HI_SWING = 2;
  localparam int unsigned HI_REGH = 1;
  localparam int unsigned HI_REGL = 0;
  // Low fault byte bit positions
  localparam int unsigned LO_PLL = 7;
  localparam int unsigned LO_QUAD = 6;
  localparam int unsigned LO_CFG = 5;
  localparam int unsigned LO_RAM = 4;
  localparam int unsigned LO_PWR = 3;
  localparam int unsigned LO_CST = 2;
  localparam int unsigned LO_FORCE = 1;
  // Response kind codes
  localparam logic [1:0] KIND_INVALID = 2'h0;
  localparam logic [1:0] KIND_VALID = 2'h1;
  localparam logic [1:0] KIND_SELFTEST = 2'h2;
  localparam logic [1:0] KIND_RW = 2'h3;
  // Thresholds
  localparam logic [15:0] QUAD_LIMIT = 16'h1000;
  localparam logic [15:0] QACC_LIMIT = 16'h0140;
  localparam logic [16:0] ST_LOW_LIM = 17'h0_0200;
  localparam logic [16:0] ST_HIGH_LIM = 17'h0_0740;
  localparam logic [15:0] ST_NOMINAL = 16'h0000;
  // Arbitrary check pattern held in ROM
  localparam logic [7:0] RAM_PATTERN = 8'hA5;
  localparam logic [7:0] RAM_UPSET_MASK = 8'h01;
  localparam int unsigned NUM_PINS = 5;
endpackage

//--- gffm_det_if.sv
// Carrier between the monitor core and its detector helpers
`timescale 1ns/100ps
`default_nettype none
interface gffm_det_if;
  logic [1:0] vreg_raw;
  logic [1:0] vreg_hold;
  logic ram_upset;
  logic ram_bad;
  modport core (output vreg_raw, output ram_upset, input vreg_hold, input ram_bad);
  modport persist (input vreg_raw, output vreg_hold);
  modport vcheck (input ram_upset, output ram_bad);
endinterface
`default_nettype wire

//--- gffm_persist.sv
// Persistence filter for the regulator threshold comparators
`timescale 1ns/100ps
`default_nettype none
module gffm_persist
  import gffm_pkg::*;
#(
  parameter int unsigned N = PERSIST_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Detector carrier
  gffm_det_if.persist det
);
  localparam int unsigned CW = $clog2(N + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(N);
  localparam logic [CW-1:0] CNT_LAST = CW'(N - 1);

  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic [CW-1:0] cnt_q;
    logic hold_q;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        cnt_q <= '0;
        hold_q <= 1'b0;
      end else if (!det.vreg_raw[g]) begin
        cnt_q <= '0;
        hold_q <= 1'b0;
      end else begin
        if (cnt_q != CNT_MAX) begin
          cnt_q <= cnt_q + 1'b1;
        end
        hold_q <= (cnt_q >= CNT_LAST); // RQ25
      end
    end
    assign det.vreg_hold[g] = hold_q;
  end
endmodule
`default_nettype wire

//--- gffm_ramchk.sv
// Volatile check register compared against its ROM pattern
`timescale 1ns/100ps
`default_nettype none
module gffm_ramchk
  import gffm_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Detector carrier
  gffm_det_if.vcheck det
);
  localparam int unsigned CW = $clog2(RAM_CHECK_CYC);
  localparam logic [CW-1:0] CNT_LAST = CW'(RAM_CHECK_CYC - 1);
  logic [7:0] vol_q;
  logic [CW-1:0] tick_q;
  logic bad_q;

  // Pattern loaded only by power-on reset
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vol_q <= RAM_PATTERN; // RQ15 RQ16
    end else if (det.ram_upset) begin
      vol_q <= vol_q ^ RAM_UPSET_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_q <= '0;
      bad_q <= 1'b0;
    end else if (tick_q == CNT_LAST) begin
      tick_q <= '0;
      bad_q <= (vol_q != RAM_PATTERN); // RQ15
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end
  assign det.ram_bad = bad_q;
endmodule
`default_nettype wire

//--- gffm_monitor.sv
// Fault-flag monitor core: sticky flags, read clear, response status
// Operation
// (RQ1) A set fault flag holds until the host reads its register.
// (RQ2) A still-present fault sets its flag again right after the read.
// (RQ3) Low fault byte rides on every sensor-data response.
// (RQ4) Read at the high fault address returns high then low byte.
// (RQ5) Host polls the fault registers at 250 Hz or faster.
// (RQ6) Gross-error flag sets whenever the response kind is forced invalid.
// (RQ7) Response self-test position carries swing fault OR self-test fault.
// (RQ8) Regulator above threshold sets regulator-high and power fault together.
// (RQ9) Regulator below threshold sets regulator-low and power fault together.
// (RQ10) Power fault sets whenever regulator-high or regulator-low is set.
// (RQ11) Phase-lock failure forces the response kind to invalid.
// (RQ12) Quadrature level above 4096 raises the quadrature fault.
// (RQ13) Quadrature accumulator at its rate-offset limit raises the quadrature fault.
// (RQ14) Config-store checksum checked every 50 us; mismatch sets its flag.
// (RQ15) ROM pattern copied at start, compared every 1 us; mismatch flags.
// (RQ16) ROM pattern reloads into the check register only at power cycle.
// (RQ17) Self-test deviation over 512 sets the self-test flag.
// (RQ18) Self-test deviation over 1856 also forces response kind invalid.
// (RQ19) Force-fault request provokes every fault in both registers.
// (RQ20) All forced faults appear within 50 ms.
// (RQ21) While force-fault is set the response kind is self-test data.
// (RQ22) Faults decay for 50 ms after force-fault is cleared.
// (RQ23) Host reads both fault registers after a power fault response.
// (RQ24) Kind codes: 00 invalid, 01 valid, 10 self-test, 11 read/write.
// (RQ25) Regulator flags need the comparator true for N consecutive cycles.
`timescale 1ns/100ps
`default_nettype none
module gffm_monitor
  import gffm_pkg::*;
#(
  parameter int unsigned DECAY_CYCLES = DECAY_CYC,
  parameter int unsigned PERSIST_CYCLES = PERSIST_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Analog detector pins
  input wire logic vreg_above_i,
  input wire logic vreg_below_i,
  input wire logic swing_low_i,
  input wire logic pll_unlock_i,
  input wire logic ram_upset_i,
  // Measurement values
  input wire logic [15:0] quad_level_i,
  input wire logic [15:0] quad_acc_i,
  input wire logic [15:0] st_value_i,
  input wire logic [15:0] cfg_sum_i,
  input wire logic [15:0] cfg_ref_i,
  // Register access
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] rd_data_o,
  output logic rd_err_o,
  // Sensor-data response
  input wire logic exchange_i,
  output logic [1:0] sd_kind_o,
  output logic [7:0] sd_flags_o,
  // Fault injection state
  output logic inject_o
);
  localparam int unsigned DW = $clog2(DECAY_CYCLES + 1);
  localparam int unsigned NW = $clog2(NVM_CHECK_CYC);
  localparam logic [NW-1:0] NVM_LAST = NW'(NVM_CHECK_CYC - 1);
  localparam logic [DW-1:0] DECAY_LOAD = DW'(DECAY_CYCLES);

  gffm_det_if det ();

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_clean;
  assign pin_raw = {ram_upset_i, pll_unlock_i, swing_low_i, vreg_below_i, vreg_above_i};

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic clean_q;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        clean_q <= 1'b0;
      end else begin
        s1_q <= pin_raw[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          clean_q <= s3_q;
        end
      end
    end
    assign pin_clean[g] = clean_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Force-fault request and decay window
  logic force_q;
  logic [DW-1:0] decay_q;
  logic inject;
  logic wr_force;
  assign wr_force = wr_i && (addr_i == ADDR_FHI);
  assign inject = force_q || (decay_q != '0);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      force_q <= 1'b0;
    end else if (wr_force) begin
      force_q <= wr_data_i[LO_FORCE]; // RQ19
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      decay_q <= '0;
    end else if (force_q) begin
      decay_q <= DECAY_LOAD; // RQ22
    end else if (decay_q != '0) begin
      decay_q <= decay_q - 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inject_o <= 1'b0;
    end else begin
      inject_o <= inject;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Detectors
  assign det.vreg_raw = {pin_clean[1] | inject, pin_clean[0] | inject}; // RQ19 RQ20
  // Forced faults flag the volatile check directly; toggling the pattern would outlive the check
  assign det.ram_upset = pin_clean[4];

  gffm_persist #(
    .N(PERSIST_CYCLES)
  ) u_persist (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .det(det.persist)
  );

  gffm_ramchk u_ramchk (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .det(det.vcheck)
  );

  logic [16:0] st_diff;
  logic [16:0] st_dev;
  logic st_minor;
  logic st_major;
  logic quad_bad;
  logic [NW-1:0] nvm_tick_q;
  logic nvm_bad;
  assign st_diff = {st_value_i[15], st_value_i} - {ST_NOMINAL[15], ST_NOMINAL};
  assign st_dev = st_diff[16] ? (17'h0_0000 - st_diff) : st_diff;
  assign st_minor = (st_dev > ST_LOW_LIM) || inject; // RQ17
  assign st_major = (st_dev > ST_HIGH_LIM) || inject; // RQ18
  // RQ12 RQ13
  assign quad_bad = (quad_level_i > QUAD_LIMIT) || (quad_acc_i >= QACC_LIMIT) || inject;
  assign nvm_bad = (nvm_tick_q == NVM_LAST) && ((cfg_sum_i != cfg_ref_i) || inject); // RQ14

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nvm_tick_q <= '0;
    end else if (nvm_tick_q == NVM_LAST) begin
      nvm_tick_q <= '0;
    end else begin
      nvm_tick_q <= nvm_tick_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Response kind selection
  logic [3:0] hi_q;
  logic [7:0] lo_q;
  logic [1:0] kind_d;
  always_comb begin
    if (force_q) begin
      kind_d = KIND_SELFTEST; // RQ21 RQ24
    end else if (lo_q[LO_PLL] || st_major) begin
      kind_d = KIND_INVALID; // RQ11 RQ18
    end else begin
      kind_d = KIND_VALID;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky fault flags; a set in the clearing cycle wins
  logic [3:0] hi_set;
  logic [7:0] lo_set;
  logic clr_hi;
  logic clr_lo;
  assign clr_hi = rd_i && (addr_i == ADDR_FHI);
  assign clr_lo = rd_i && ((addr_i == ADDR_FHI) || (addr_i == ADDR_FLO));

  always_comb begin
    hi_set = '0;
    hi_set[HI_GROSS] = (kind_d == KIND_INVALID) || inject; // RQ6
    hi_set[HI_SWING] = pin_clean[2] || inject;
    hi_set[HI_REGH] = det.vreg_hold[0]; // RQ8
    hi_set[HI_REGL] = det.vreg_hold[1]; // RQ9
    lo_set = '0;
    lo_set[LO_PLL] = pin_clean[3] || inject;
    lo_set[LO_QUAD] = quad_bad;
    lo_set[LO_CFG] = nvm_bad;
    lo_set[LO_RAM] = det.ram_bad || inject; // RQ15
    // Regulator flags cleared by this very read must not re-set the power fault
    lo_set[LO_PWR] = det.vreg_hold[0] || det.vreg_hold[1] || // RQ8 RQ9 RQ10
      ((hi_q[HI_REGH] || hi_q[HI_REGL]) && !clr_hi);
    lo_set[LO_CST] = st_minor;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hi_q <= '0;
    end else begin
      hi_q <= (hi_q & ~{4{clr_hi}}) | hi_set; // RQ1 RQ2
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lo_q <= '0;
    end else begin
      lo_q[7:2] <= (lo_q[7:2] & ~{6{clr_lo}}) | lo_set[7:2]; // RQ1 RQ2
      lo_q[LO_FORCE] <= wr_force ? wr_data_i[LO_FORCE] : lo_q[LO_FORCE];
      lo_q[0] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read and write answers
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= '0;
      rd_err_o <= 1'b0;
    end else if (wr_i) begin
      rd_data_o <= wr_data_i;
      rd_err_o <= !wr_force;
    end else if (rd_i) begin
      rd_err_o <= 1'b0;
      unique case (addr_i)
        ADDR_QUAD: rd_data_o <= quad_level_i;
        ADDR_FHI: rd_data_o <= {4'h0, hi_q, lo_q}; // RQ4
        ADDR_FLO: rd_data_o <= {lo_q, 8'h00};
        default: begin
          rd_data_o <= '0;
          rd_err_o <= 1'b1;
        end
      endcase
    end
  end

  // Sensor-data response status latched at the frame start
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sd_kind_o <= KIND_VALID;
      sd_flags_o <= '0;
    end else if (exchange_i) begin
      sd_kind_o <= kind_d;
      sd_flags_o <= lo_q; // RQ3
      sd_flags_o[LO_CST] <= lo_q[LO_CST] | hi_q[HI_SWING]; // RQ7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sticky_high_a: assert property (hi_q[HI_REGH] && !clr_hi |=> hi_q[HI_REGH]) // RQ1
    else $error("regulator-high flag dropped without a read");
  reassert_a: assert property (clr_hi && hi_set[HI_SWING] |=> hi_q[HI_SWING]) // RQ2
    else $error("persisting swing fault not reasserted after read");
  word_order_a: assert property (rd_i && addr_i == ADDR_FHI && !wr_i |=> // RQ4
    rd_data_o == {4'h0, $past(hi_q), $past(lo_q)})
    else $error("fault word not high byte first");
  resp_flags_a: assert property (exchange_i |=> sd_flags_o[LO_CST] == // RQ3 RQ7
    ($past(lo_q[LO_CST]) | $past(hi_q[HI_SWING])) && sd_flags_o[7:3] == $past(lo_q[7:3]))
    else $error("response fault byte wrong");
  gross_a: assert property (kind_d == KIND_INVALID |=> hi_q[HI_GROSS]) // RQ6
    else $error("gross flag missing on invalid kind");
  pwr_follow_a: assert property ((hi_q[HI_REGH] || hi_q[HI_REGL]) |-> lo_q[LO_PWR]) // RQ10
    else $error("power fault not following regulator flag");
  pwr_same_a: assert property ($rose(hi_q[HI_REGL]) |-> lo_q[LO_PWR]) // RQ9
    else $error("power fault late for regulator-low");
  pll_kind_a: assert property (exchange_i && lo_q[LO_PLL] && !force_q |=> // RQ11
    sd_kind_o == KIND_INVALID)
    else $error("phase-lock fault did not force invalid kind");
  force_kind_a: assert property (exchange_i && force_q |=> sd_kind_o == KIND_SELFTEST) // RQ21
    else $error("force request not reported as self-test data");
  quad_flag_a: assert property (quad_level_i > QUAD_LIMIT |=> lo_q[LO_QUAD]) // RQ12
    else $error("quadrature fault missing");
  st_flag_a: assert property (st_dev > ST_LOW_LIM |=> lo_q[LO_CST]) // RQ17
    else $error("self-test fault missing");

  force_c: cover property (wr_force && wr_data_i[LO_FORCE] ##1 force_q);
  clear_c: cover property (clr_hi && hi_q != '0 ##1 hi_q == '0);
  invalid_c: cover property (exchange_i && kind_d == KIND_INVALID);
  decay_c: cover property ($fell(force_q) ##1 inject);
endmodule
`default_nettype wire

//--- gffm_host_model.sv
// Host controller model: register accesses and sensor-data exchanges
`timescale 1ns/100ps
`default_nettype none
module gffm_host_model
  import gffm_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Requests to the device
  output logic rd_o,
  output logic wr_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [15:0] wr_data_o,
  output logic exchange_o,
  // Answers from the device
  input wire logic [15:0] rd_data_i,
  input wire logic rd_err_i,
  input wire logic [1:0] sd_kind_i,
  input wire logic [7:0] sd_flags_i
);
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = '0;
    wr_data_o = 16'h0000;
    exchange_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // One access: request holds across one rising edge, answer read after it
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d,
      output logic [15:0] q, output logic err);
    @(negedge clock_i);
    rd_o = !wr;
    wr_o = wr;
    addr_o = a;
    wr_data_o = d;
    @(negedge clock_i);
    rd_o = 1'b0;
    wr_o = 1'b0;
    // Released lines change rather than keep the last value
    addr_o = ~a;
    wr_data_o = ~d;
    q = rd_data_i;
    err = rd_err_i;
  endtask

  task automatic exch(output logic [1:0] k, output logic [7:0] f);
    @(negedge clock_i);
    exchange_o = 1'b1;
    @(negedge clock_i);
    exchange_o = 1'b0;
    k = sd_kind_i;
    f = sd_flags_i;
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking testbench for the gyro fault-flag monitor
`timescale 1ns/100ps
`default_nettype none
module tb
  import gffm_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic vreg_above_i = 1'b0;
  logic vreg_below_i = 1'b0;
  logic swing_low_i = 1'b0;
  logic pll_unlock_i = 1'b0;
  logic ram_upset_i = 1'b0;
  logic [15:0] quad_level_i = 16'h0000;
  logic [15:0] quad_acc_i = 16'h0000;
  logic [15:0] st_value_i = 16'h0000;
  logic [15:0] cfg_sum_i = 16'h1234;
  logic [15:0] cfg_ref_i = 16'h1234;
  logic rd_i;
  logic wr_i;
  logic exchange_i;
  logic [ADDR_W-1:0] addr_i;
  logic [15:0] wr_data_i;
  logic [15:0] rd_data_o;
  logic rd_err_o;
  logic [1:0] sd_kind_o;
  logic [7:0] sd_flags_o;
  logic inject_o;
  logic [15:0] st_tab [8] = '{16'h0200, 16'h0201, 16'h0740, 16'h0741,
                              16'hFE00, 16'hFDFF, 16'hF8C0, 16'hF8BF};
  logic [7:0] cst_tab = 8'hEE;
  logic [7:0] inv_tab = 8'h88;
  int err_total = 0;
  int cmp_count = 0;

  always #50 clock_i = ~clock_i;

  gffm_monitor #(.DECAY_CYCLES(40), .PERSIST_CYCLES(4)) uut (
    .clock_i(clock_i), .rst_b_i(rst_b_i),
    .vreg_above_i(vreg_above_i), .vreg_below_i(vreg_below_i),
    .swing_low_i(swing_low_i), .pll_unlock_i(pll_unlock_i), .ram_upset_i(ram_upset_i),
    .quad_level_i(quad_level_i), .quad_acc_i(quad_acc_i), .st_value_i(st_value_i),
    .cfg_sum_i(cfg_sum_i), .cfg_ref_i(cfg_ref_i),
    .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .rd_data_o(rd_data_o), .rd_err_o(rd_err_o),
    .exchange_i(exchange_i), .sd_kind_o(sd_kind_o), .sd_flags_o(sd_flags_o),
    .inject_o(inject_o));

  gffm_host_model host (
    .clock_i(clock_i), .rd_o(rd_i), .wr_o(wr_i), .addr_o(addr_i),
    .wr_data_o(wr_data_i), .exchange_o(exchange_i),
    .rd_data_i(rd_data_o), .rd_err_i(rd_err_o),
    .sd_kind_i(sd_kind_o), .sd_flags_i(sd_flags_o));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d,
      input logic [15:0] exp, input logic eerr);
    logic [15:0] q;
    logic e;
    host.access(w, a, d, q, e);
    chk(q, exp);
    chk({15'h0000, e}, {15'h0000, eerr});
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000, exp, 1'b0);
  endtask

  task automatic ex(input logic [1:0] kexp, input logic [7:0] fexp);
    logic [1:0] k;
    logic [7:0] f;
    host.exch(k, f);
    chk({6'h00, k, f}, {6'h00, kexp, fexp});
  endtask

  // Read the high fault address three times so every sticky flag drains
  task automatic clr;
    logic [15:0] q;
    logic e;
    repeat (3) host.access(1'b0, ADDR_FHI, 16'h0000, q, e);
  endtask

  task automatic reset_dut;
    rst_b_i = 1'b0;
    wt(20);
    rst_b_i = 1'b1;
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    final_report;
  end

  initial begin
    reset_dut;
    ex(KIND_VALID, 8'h00);
    rd(ADDR_FHI, 16'h0000);
    acc(1'b0, 9'h1FF, 16'h0000, 16'h0000, 1'b1);
    acc(1'b1, ADDR_QUAD, 16'h5555, 16'h5555, 1'b1);
    // Quadrature level just over and exactly at the limit
    quad_level_i = 16'h1001;
    wt(3);
    rd(ADDR_QUAD, 16'h1001);
    quad_level_i = 16'h1000;
    wt(3);
    rd(ADDR_FHI, 16'h0040);
    rd(ADDR_FHI, 16'h0000);
    quad_acc_i = 16'h013F;
    wt(3);
    rd(ADDR_FHI, 16'h0000);
    quad_acc_i = 16'h0140;
    wt(3);
    rd(ADDR_FHI, 16'h0040);
    rd(ADDR_FHI, 16'h0040);
    ex(KIND_VALID, 8'h40);
    quad_acc_i = 16'h0000;
    rd(ADDR_FHI, 16'h0040);
    rd(ADDR_FHI, 16'h0000);
    // Regulator high then low: glitch first, then a held fault
    for (int i = 0; i < 2; i++) begin
      {vreg_above_i, vreg_below_i} = i ? 2'b01 : 2'b10;
      wt(2);
      {vreg_above_i, vreg_below_i} = 2'b00;
      wt(10);
      rd(ADDR_FHI, 16'h0000);
      {vreg_above_i, vreg_below_i} = i ? 2'b01 : 2'b10;
      wt(12);
      ex(KIND_VALID, 8'h08);
      {vreg_above_i, vreg_below_i} = 2'b00;
      wt(8);
      rd(ADDR_FLO, 16'h0800);
      rd(ADDR_FHI, i ? 16'h0108 : 16'h0208);
      rd(ADDR_FHI, 16'h0000);
    end
    swing_low_i = 1'b1;
    wt(8);
    ex(KIND_VALID, 8'h04);
    swing_low_i = 1'b0;
    wt(8);
    rd(ADDR_FHI, 16'h0400);
    pll_unlock_i = 1'b1;
    wt(8);
    ex(KIND_INVALID, 8'h80);
    pll_unlock_i = 1'b0;
    wt(8);
    rd(ADDR_FHI, 16'h0880);
    clr;
    rd(ADDR_FHI, 16'h0000);
    // Self-test deviations on both sides of both thresholds
    for (int i = 0; i < 8; i++) begin
      st_value_i = st_tab[i];
      wt(8);
      ex(inv_tab[i] ? KIND_INVALID : KIND_VALID, {5'h00, cst_tab[i], 2'h0});
      st_value_i = 16'h0000;
      wt(8);
      rd(ADDR_FHI, {4'h0, inv_tab[i], 8'h00, cst_tab[i], 2'h0});
      clr;
    end
    cfg_sum_i = 16'h1235;
    wt(510);
    cfg_sum_i = 16'h1234;
    wt(2);
    rd(ADDR_FHI, 16'h0020);
    rd(ADDR_FHI, 16'h0000);
    // Forced faults, then the decay window
    acc(1'b1, ADDR_FHI, 16'h0002, 16'h0002, 1'b0);
    wt(1);
    chk({15'h0000, inject_o}, 16'h0001);
    // The forced checksum fault waits for the next periodic config check
    wt(NVM_CHECK_CYC + 12);
    ex(KIND_SELFTEST, 8'hFE);
    rd(ADDR_FHI, 16'h0FFE);
    acc(1'b1, ADDR_FHI, 16'h0000, 16'h0000, 1'b0);
    wt(30);
    chk({15'h0000, inject_o}, 16'h0001);
    wt(20);
    chk({15'h0000, inject_o}, 16'h0000);
    reset_dut;
    rd(ADDR_FHI, 16'h0000);
    // Upset the volatile check register; only a power cycle restores it
    ram_upset_i = 1'b1;
    wt(5);
    ram_upset_i = 1'b0;
    wt(20);
    rd(ADDR_FLO, 16'h1000);
    rd(ADDR_FLO, 16'h1000);
    reset_dut;
    wt(15);
    rd(ADDR_FLO, 16'h0000);
    final_report;
  end
endmodule
`default_nettype wire
